// [dfs_defines.svh]
// dfs_defines.svh: named constants for the dual fifo flag synchroniser.
// assumes inclusion by bare name from the design file only.
`ifndef DFS_DEFINES_SVH
`define DFS_DEFINES_SVH
// =====================================================================
// sub-access counts that complete one 36-bit long word
`define DFS_WORD_LAST 2'h1
`define DFS_BYTE_LAST 2'h3
// =====================================================================
// reset values
`define DFS_PTR_RST 7'h00
`define DFS_CNT_RST 2'h0
`define DFS_FLAG_RST 1'h0
`define DFS_FULL_FLAG_RST 1'h1
`endif

// [dfs_pkg.sv]
// dfs_pkg.sv: types shared by the dual fifo flag synchroniser.
// assumes nothing of its surroundings.
package dfs_pkg;
  // bus size selected on port b or port c
  typedef enum logic {
    DFS_SIZE_WORD = 1'b0,
    DFS_SIZE_BYTE = 1'b1
  } dfs_size_type;
endpackage : dfs_pkg

// [dfs_flag_sync.sv]
// dfs_flag_sync.sv: flag logic for two fifos with three port clocks.
// assumes port clocks and strobes are pins, slower than ref_clk / 4,
// sampled here; data storage lives elsewhere.
// How it works
// - port b read frees fifo1, full flag a rises
// - port b reads reach full flag a one port a cycle late, two when they land on a port a edge
// - full flag a counts final long-word read
// - port c write completing long word drops full
// - almost-empty b updates per long word read
// - almost-empty a counts final long-word write
// - almost-full a rises after long-word reads drain
// - empty b drops on last sized read
`timescale 1ns/100ps
`default_nettype none
`include "dfs_defines.svh"
module dfs_flag_sync #(
  parameter int DEPTH = 64,
  parameter int PW = 7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // port a pins
  input wire logic porta_clock,
  input wire logic porta_chip_select_n,
  input wire logic porta_write_not_read,
  input wire logic porta_enable,
  // port b pins
  input wire logic portb_clock,
  input wire logic portb_read_enable,
  input wire dfs_pkg::dfs_size_type portb_size,
  // port c pins
  input wire logic portc_clock,
  input wire logic portc_write_enable,
  input wire dfs_pkg::dfs_size_type portc_size,
  // almost flag offset
  input wire logic [PW-1:0] flag_offset,
  // flags, active low
  output logic porta_full_flag,
  output logic porta_almost_full_flag,
  output logic porta_empty_flag,
  output logic porta_almost_empty_flag,
  output logic portb_empty_flag,
  output logic portb_almost_empty_flag,
  output logic portc_full_flag,
  output logic portc_almost_full_flag
);
  import dfs_pkg::*;
  localparam int NPIN = 11;
  localparam logic [PW-1:0] DEPTH_V = PW'(DEPTH);
  // =====================================================================
  // pin synchronisers
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  logic [2:0] clk_s3_reg;
  logic [PW-1:0] offset_reg;
  // two-flop sampling of every port pin
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {portc_size, portc_write_enable, portc_clock,
                     portb_size, portb_read_enable, portb_clock,
                     porta_enable, porta_write_not_read,
                     porta_chip_select_n, porta_clock, 1'b0};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  // third stage only for rising-edge detection of port clocks
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_s3_reg <= '0;
    end else begin
      clk_s3_reg <= {pin_s2_reg[8], pin_s2_reg[5], pin_s2_reg[1]};
    end
  end
  // offset is static configuration, sampled once per cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_reg <= '0;
    end else begin
      offset_reg <= flag_offset;
    end
  end
  logic a_edge;
  logic b_edge;
  logic c_edge;
  logic a_sel;
  logic b_byte;
  logic c_byte;
  assign a_edge = pin_s2_reg[1] & ~clk_s3_reg[0];
  assign b_edge = pin_s2_reg[5] & ~clk_s3_reg[1];
  assign c_edge = pin_s2_reg[8] & ~clk_s3_reg[2];
  assign a_sel = ~pin_s2_reg[2] & pin_s2_reg[4];
  assign b_byte = pin_s2_reg[7];
  assign c_byte = pin_s2_reg[10];
  // =====================================================================
  // accepted accesses
  logic a_wr_go;
  logic a_rd_go;
  logic b_rd_go;
  logic c_wr_go;
  assign a_wr_go = a_edge & a_sel & pin_s2_reg[3] & porta_full_flag;
  assign a_rd_go = a_edge & a_sel & ~pin_s2_reg[3] & porta_empty_flag;
  assign b_rd_go = b_edge & pin_s2_reg[6] & portb_empty_flag;
  assign c_wr_go = c_edge & pin_s2_reg[9] & portc_full_flag;
  // =====================================================================
  // sub-access counters for long-word assembly
  logic [1:0] b_cnt_reg;
  logic [1:0] c_cnt_reg;
  logic b_last;
  logic c_last;
  assign b_last = b_rd_go &
    (b_cnt_reg == (b_byte ? `DFS_BYTE_LAST : `DFS_WORD_LAST));
  assign c_last = c_wr_go &
    (c_cnt_reg == (c_byte ? `DFS_BYTE_LAST : `DFS_WORD_LAST));
  // count reads and writes within a long word
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      b_cnt_reg <= `DFS_CNT_RST;
      c_cnt_reg <= `DFS_CNT_RST;
    end else begin
      if (b_last) begin
        b_cnt_reg <= `DFS_CNT_RST;
      end else if (b_rd_go) begin
        b_cnt_reg <= b_cnt_reg + 2'h1;
      end
      if (c_last) begin
        c_cnt_reg <= `DFS_CNT_RST;
      end else if (c_wr_go) begin
        c_cnt_reg <= c_cnt_reg + 2'h1;
      end
    end
  end
  // =====================================================================
  // long-word pointers and their samples in the far domains
  logic [PW-1:0] wr1_reg;
  logic [PW-1:0] rd1_reg;
  logic [PW-1:0] wr2_reg;
  logic [PW-1:0] rd2_reg;
  logic [PW-1:0] rd1_seen_a_reg;
  logic [PW-1:0] wr1_seen_b_reg;
  logic [PW-1:0] wr2_seen_a_reg;
  logic [PW-1:0] rd2_seen_c_reg;
  logic [PW-1:0] wr1_next;
  logic [PW-1:0] rd1_next;
  logic [PW-1:0] wr2_next;
  logic [PW-1:0] rd2_next;
  assign wr1_next = wr1_reg + PW'(a_wr_go);
  assign rd1_next = rd1_reg + PW'(b_last);
  assign wr2_next = wr2_reg + PW'(c_last);
  assign rd2_next = rd2_reg + PW'(a_rd_go);
  // pointers advance once per long word
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr1_reg <= `DFS_PTR_RST;
      rd1_reg <= `DFS_PTR_RST;
      wr2_reg <= `DFS_PTR_RST;
      rd2_reg <= `DFS_PTR_RST;
    end else begin
      wr1_reg <= wr1_next;
      rd1_reg <= rd1_next;
      wr2_reg <= wr2_next;
      rd2_reg <= rd2_next;
    end
  end
  // far pointers are sampled on the flag's own port edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd1_seen_a_reg <= `DFS_PTR_RST;
      wr2_seen_a_reg <= `DFS_PTR_RST;
      wr1_seen_b_reg <= `DFS_PTR_RST;
      rd2_seen_c_reg <= `DFS_PTR_RST;
    end else begin
      if (a_edge) begin
        rd1_seen_a_reg <= rd1_reg;
        wr2_seen_a_reg <= wr2_reg;
      end
      if (b_edge) begin
        wr1_seen_b_reg <= wr1_reg;
      end
      if (c_edge) begin
        rd2_seen_c_reg <= rd2_reg;
      end
    end
  end
  // =====================================================================
  // occupancy as seen by each flag domain, own access included at once
  logic [PW-1:0] occ1_a;
  logic [PW-1:0] occ1_b;
  logic [PW-1:0] occ2_a;
  logic [PW-1:0] occ2_c;
  assign occ1_a = wr1_next - rd1_seen_a_reg;
  assign occ1_b = wr1_seen_b_reg - rd1_next;
  assign occ2_a = wr2_seen_a_reg - rd2_next;
  assign occ2_c = wr2_next - rd2_seen_c_reg;
  // port a flags update on port a edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      porta_full_flag <= `DFS_FULL_FLAG_RST;
      porta_almost_full_flag <= `DFS_FULL_FLAG_RST;
      porta_empty_flag <= `DFS_FLAG_RST;
      porta_almost_empty_flag <= `DFS_FLAG_RST;
    end else if (a_edge) begin
      porta_full_flag <= (occ1_a != DEPTH_V);
      porta_almost_full_flag <= ((DEPTH_V - occ1_a) > offset_reg);
      porta_empty_flag <= (occ2_a != '0);
      porta_almost_empty_flag <= (occ2_a > offset_reg);
    end
  end
  // port b flags update on port b edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      portb_empty_flag <= `DFS_FLAG_RST;
      portb_almost_empty_flag <= `DFS_FLAG_RST;
    end else if (b_edge) begin
      portb_empty_flag <= (occ1_b != '0);
      portb_almost_empty_flag <= (occ1_b > offset_reg);
    end
  end
  // port c flags update on port c edges
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      portc_full_flag <= `DFS_FULL_FLAG_RST;
      portc_almost_full_flag <= `DFS_FULL_FLAG_RST;
    end else if (c_edge) begin
      portc_full_flag <= (occ2_c != DEPTH_V);
      portc_almost_full_flag <= ((DEPTH_V - occ2_c) > offset_reg);
    end
  end
  // =====================================================================
  // checks
  default clocking dfs_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_fulla_drop: assert property (
    a_edge && occ1_a == DEPTH_V |=> !porta_full_flag)
    else $error("port a full flag not low at full");
  a_fulla_rise: assert property (
    a_edge && occ1_a != DEPTH_V |=> porta_full_flag)
    else $error("port a full flag not high with room");
  a_partial_read: assert property (
    b_rd_go && !b_last |=> rd1_reg == $past(rd1_reg))
    else $error("partial read moved fifo1 pointer");
  a_fullc_drop: assert property (
    c_edge && occ2_c == DEPTH_V |=> !portc_full_flag)
    else $error("port c full flag not low at full");
  a_aeb_hold: assert property (
    !b_edge |=> $stable(portb_almost_empty_flag))
    else $error("almost-empty b moved off its edge");
  a_aea_level: assert property (
    a_edge |=> porta_almost_empty_flag == ($past(occ2_a) > offset_reg))
    else $error("almost-empty a wrong level");
  a_long_write: assert property (
    c_wr_go && c_byte && c_cnt_reg != `DFS_BYTE_LAST |=> $stable(wr2_reg))
    else $error("partial byte write moved fifo2 pointer");
  a_afa_level: assert property (
    a_edge |=> porta_almost_full_flag ==
      ((DEPTH_V - $past(occ1_a)) > offset_reg))
    else $error("almost-full a wrong level");
  a_efb_drop: assert property (
    b_edge && occ1_b == '0 |=> !portb_empty_flag)
    else $error("empty b flag not low when drained");
  a_seen_lag: assert property (
    a_edge |=> rd1_seen_a_reg == $past(rd1_reg))
    else $error("port a sample of read pointer wrong");
endmodule : dfs_flag_sync
`default_nettype wire

// [dfs_far_end.sv]
// dfs_far_end.sv: far-end model driving the three port pins.
// assumes ref_clk runs free; the bench calls one task at a time.
`timescale 1ns/100ps
`default_nettype none
module dfs_far_end (
  // reference clock
  input wire logic ref_clk,
  // port a
  output logic porta_clock,
  output logic porta_chip_select_n,
  output logic porta_write_not_read,
  output logic porta_enable,
  // port b
  output logic portb_clock,
  output logic portb_read_enable,
  // port c
  output logic portc_clock,
  output logic portc_write_enable
);
  // ==================================================================
  // idle pin levels
  initial begin
    {porta_clock, portb_clock, portc_clock} = 3'h0;
    {porta_write_not_read, porta_enable} = 2'h0;
    {portb_read_enable, portc_write_enable} = 2'h0;
    porta_chip_select_n = 1'b1;
  end

  // drive the clock pin of one port: 0 = a, 1 = b, else c
  task automatic set_clk(input logic [1:0] sel, input logic lvl);
    case (sel)
      2'h0: porta_clock = lvl;
      2'h1: portb_clock = lvl;
      default: portc_clock = lvl;
    endcase
  endtask : set_clk

  // one port clock cycle: 4 ref_clk high, 4 low, strobes set before
  task automatic pulse(input logic [1:0] sel);
    repeat (2) @(negedge ref_clk);
    set_clk(sel, 1'b1);
    repeat (4) @(negedge ref_clk);
    set_clk(sel, 1'b0);
    repeat (2) @(negedge ref_clk);
  endtask : pulse

  // port a cycle, access when en is high
  task automatic cyc_a(input logic en, input logic wr);
    @(negedge ref_clk);
    porta_chip_select_n = ~en;
    porta_enable = en;
    porta_write_not_read = wr;
    pulse(2'h0);
    porta_enable = 1'b0;
    porta_chip_select_n = 1'b1;
  endtask : cyc_a

  // port b cycle, read when en is high
  task automatic cyc_b(input logic en);
    @(negedge ref_clk);
    portb_read_enable = en;
    pulse(2'h1);
    portb_read_enable = 1'b0;
  endtask : cyc_b

  // port c cycle, write when en is high
  task automatic cyc_c(input logic en);
    @(negedge ref_clk);
    portc_write_enable = en;
    pulse(2'h2);
    portc_write_enable = 1'b0;
  endtask : cyc_c
endmodule : dfs_far_end
`default_nettype wire

// [dfs_flag_sync_test.sv]
// dfs_flag_sync_test.sv: self-checking bench for the flag logic.
// assumes dfs_far_end drives the port pins; flags are active low.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, e); end end
module dfs_flag_sync_test;
  import dfs_pkg::*;
  logic ref_clk, rst_b;
  // almost flag offset, driven by the bench
  logic [6:0] offset;
  wire logic pa_clk, pa_cs_n, pa_wnr, pa_en, pb_clk, pb_re;
  wire logic pc_clk, pc_we, fa, afa, ea, aea, eb, aeb, fc, afc;
  dfs_size_type portb_size, portc_size;
  int error_cnt = 0;
  int comparisons = 0;
  // row: [7] c size, [6] expected empty flag at a, [2:0] c writes
  logic [7:0] rows [4] = '{8'h01, 8'h42, 8'h83, 8'hC4};

  // ==================================================================
  // design and far-end model
  dfs_flag_sync #(.DEPTH(64), .PW(7)) u_dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .porta_clock(pa_clk), .porta_chip_select_n(pa_cs_n),
    .porta_write_not_read(pa_wnr), .porta_enable(pa_en),
    .portb_clock(pb_clk), .portb_read_enable(pb_re),
    .portb_size(portb_size), .portc_clock(pc_clk),
    .portc_write_enable(pc_we), .portc_size(portc_size),
    .flag_offset(offset), .porta_full_flag(fa),
    .porta_almost_full_flag(afa), .porta_empty_flag(ea),
    .porta_almost_empty_flag(aea), .portb_empty_flag(eb),
    .portb_almost_empty_flag(aeb), .portc_full_flag(fc),
    .portc_almost_full_flag(afc));
  dfs_far_end u_far (.ref_clk(ref_clk), .porta_clock(pa_clk),
    .porta_chip_select_n(pa_cs_n), .porta_write_not_read(pa_wnr),
    .porta_enable(pa_en), .portb_clock(pb_clk),
    .portb_read_enable(pb_re), .portc_clock(pc_clk),
    .portc_write_enable(pc_we));

  // 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // reset for 8 cycles, flags checked while held
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK({fa, afa, ea, aea, eb, aeb, fc, afc}, 8'hC3)
    @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask : do_reset

  // counts, verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    complete_run();
  end

  // ==================================================================
  // main sequence
  initial begin
    portb_size = DFS_SIZE_WORD;
    portc_size = DFS_SIZE_WORD;
    // offset 0: almost-empty a tracks any stored long word
    offset = 7'h00;
    // port c long words seen as fifo2 not empty at port a
    foreach (rows[i]) begin
      do_reset();
      portc_size = dfs_size_type'(rows[i][7]);
      repeat (rows[i][2:0]) u_far.cyc_c(1'b1);
      u_far.cyc_a(1'b0, 1'b0);
      `CHK(ea, 1'b0)
      repeat (2) u_far.cyc_a(1'b0, 1'b0);
      `CHK(ea, rows[i][6])
      `CHK(aea, rows[i][6])
      // a port a read drains the only long word at once
      u_far.cyc_a(1'b1, 1'b0);
      `CHK({ea, aea}, 2'h0)
    end
    // one long word through fifo1, read back in bytes
    do_reset();
    offset = 7'h04;
    u_far.cyc_a(1'b1, 1'b1);
    repeat (3) u_far.cyc_b(1'b0);
    `CHK(eb, 1'b1)
    portb_size = DFS_SIZE_BYTE;
    repeat (3) u_far.cyc_b(1'b1);
    `CHK(eb, 1'b1)
    `CHK(aeb, 1'b0)
    u_far.cyc_b(1'b1);
    `CHK(eb, 1'b0)
    // fill fifo1, then free it word by word
    do_reset();
    portb_size = DFS_SIZE_WORD;
    repeat (64) u_far.cyc_a(1'b1, 1'b1);
    `CHK({fa, afa}, 2'h0)
    repeat (3) u_far.cyc_b(1'b0);
    `CHK(aeb, 1'b1)
    u_far.cyc_b(1'b1);
    repeat (3) u_far.cyc_a(1'b0, 1'b0);
    `CHK(fa, 1'b0)
    u_far.cyc_b(1'b1);
    u_far.cyc_a(1'b0, 1'b0);
    `CHK(fa, 1'b0)
    repeat (2) u_far.cyc_a(1'b0, 1'b0);
    `CHK(fa, 1'b1)
    repeat (8) u_far.cyc_b(1'b1);
    repeat (3) u_far.cyc_a(1'b0, 1'b0);
    `CHK(afa, 1'b1)
    // 59 long words stored: room 5 is not above offset 5
    offset = 7'h05;
    u_far.cyc_a(1'b0, 1'b0);
    `CHK(afa, 1'b0)
    // fill fifo2 to the last long word, word size
    do_reset();
    portc_size = DFS_SIZE_WORD;
    repeat (127) u_far.cyc_c(1'b1);
    `CHK(fc, 1'b1)
    `CHK(afc, 1'b0)
    u_far.cyc_c(1'b1);
    `CHK(fc, 1'b0)
    complete_run();
  end
endmodule : dfs_flag_sync_test
`default_nettype wire
